// *** src/beat_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_params.svh"

module beat_buffer #(
   parameter int WIDTH = `SB_BEAT_W,
   parameter int DEPTH = `SB_BUF_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0]    rd_ptr;
   logic [PW-1:0]    wr_ptr;
   logic [PW:0]      fill;
   logic [PW-1:0]    next_rd_ptr;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW:0]      next_fill;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         return '0;
      end
      return PW'(p + 1'b1);
   endfunction

   assign in_ready_o  = (fill < (PW + 1)'(DEPTH));
   assign out_valid_o = (fill != '0);
   assign out_data_o  = slot[rd_ptr];

   // ============================================================
   // Pointer and fill update.
   always_comb begin
      push        = in_valid_i & in_ready_o;
      pop         = out_valid_o & out_ready_i;
      next_rd_ptr = pop ? step_ptr(rd_ptr) : rd_ptr;
      next_wr_ptr = push ? step_ptr(wr_ptr) : wr_ptr;
      next_fill   = fill;
      if (push && !pop) begin
         next_fill = (PW + 1)'(fill + 1'b1);
      end else if (pop && !push) begin
         next_fill = (PW + 1)'(fill - 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         fill   <= '0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         fill   <= next_fill;
      end
   end

   // Slots carry no reset; only the fill count says what is valid.
   always_ff @(posedge clk_i) begin
      if (push) begin
         slot[wr_ptr] <= in_data_i;
      end
   end

endmodule

`default_nettype wire

// *** src/pipelined_sram_burst_control.sv ***
// Function
// - Hold low, all selects true, load low: load address, data moves two cycles later.
// - Advance high during a live burst steps the burst counter and uses the internal address; with no live burst it is an idle cycle.
// - Read/write pin ignored on advance; burst keeps the type of its load.
// - Any select false with load low: deselect, no new access, pending beats finish.
// - Data bus released two cycles after a deselect cycle begins.
// - Hold high on an edge: no command taken; the only effect of that edge is to clear stall_o.
// - Suspended cycle: every register but stall_o, every counter, pipeline and data pin keeps its value.
// - Each active-low lane select covers eight data bits plus one parity bit.
// - Any lane mix per write; all selects high writes nothing; ignored on reads.
// - Narrow configuration has only lanes one and two.
// - Order pin high: low address bits are loaded value xor count.
// - Order pin low: low address bits are loaded value plus count modulo four.
// - After the fourth beat the counter wraps and keeps stepping the same way.
// - Data outputs stay released from the first edge until a read drives them.
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_params.svh"

module pipelined_sram_burst_control (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    cycle_hold_n_i,
   input  wire logic                    read_not_write_i,
   input  wire logic                    select_a_n_i,
   input  wire logic                    select_b_i,
   input  wire logic                    select_c_n_i,
   input  wire logic                    advance_or_load_i,
   input  wire logic [`SB_LANES-1:0]    byte_lane_write_n_i,
   input  wire logic                    burst_order_sel_i,
   input  wire logic                    narrow_config_i,
   input  wire logic [`SB_ADDR_W-1:0]   address_i,
   input  wire logic [`SB_DATA_W-1:0]   data_in_i,
   input  wire logic                    bus_ready_i,
   output logic [`SB_DATA_W-1:0]        data_out_o,
   output logic                         data_oe_o,
   output sram_burst_pkg::cycle_kind_t  cycle_kind_o,
   output logic [`SB_CNT_W-1:0]         burst_count_o,
   output logic                         stall_o
);

   // ============================================================
   // Decoding helpers.

   // Builds the bit mask of the enabled lanes; lanes above the narrow
   // width never exist in the narrow configuration.
   function automatic logic [`SB_DATA_W-1:0] lane_mask(
      input logic [`SB_LANES-1:0] lanes_n,
      input logic                 narrow
   );
      logic [`SB_DATA_W-1:0] m;
      logic [`SB_LANES-1:0]  en;
      m  = '0;
      en = ~lanes_n;
      for (int i = 0; i < `SB_LANES; i++) begin
         if (narrow && (i >= `SB_NARROW_LANES)) begin
            en[i] = 1'b0;
         end
         m[i*`SB_LANE_W +: `SB_LANE_W] = {`SB_LANE_W{en[i]}};
         m[`SB_PAR_LSB + i]            = en[i];
      end
      return m;
   endfunction

   // Low address bits of a burst beat from the loaded bits and the count.
   // The loaded bits stay in base_addr for the whole burst; only the count
   // moves, and being two bits wide it wraps by itself after four beats.
   function automatic logic [`SB_CNT_W-1:0] burst_low(
      input logic [`SB_CNT_W-1:0] base,
      input logic [`SB_CNT_W-1:0] cnt,
      input logic                 interleave
   );
      if (interleave) begin
         return base ^ cnt;
      end
      return `SB_CNT_W'(base + cnt);
   endfunction

   // ============================================================
   // Command decode and burst state.

   sram_burst_pkg::cycle_kind_t kind;
   sram_burst_pkg::cycle_kind_t next_kind;
   sram_burst_pkg::cycle_kind_t new_kind;
   logic                        burst_live;
   logic                        next_burst_live;
   logic                        burst_wr;
   logic                        next_burst_wr;
   logic [`SB_ADDR_W-1:0]       base_addr;
   logic [`SB_ADDR_W-1:0]       next_base_addr;
   logic [`SB_CNT_W-1:0]        count;
   logic [`SB_CNT_W-1:0]        next_count;
   logic [`SB_CNT_W-1:0]        step_count;
   logic [`SB_BEAT_W-1:0]       stage_beat;
   logic [`SB_BEAT_W-1:0]       next_stage_beat;
   logic [`SB_ADDR_W-1:0]       beat_addr;
   logic                        beat_rd;
   logic                        beat_wr;
   logic                        run;
   logic                        advance;
   logic                        selected;
   logic                        buf_in_ready;

   // The decode runs every cycle, but only an edge that is neither held
   // nor refused by a full buffer commits anything. The beat built here
   // sits in stage_beat for one edge and enters the buffer on the next,
   // which together with the data-stage register gives the two-cycle gap
   // between a command and its data.
   always_comb begin
      run        = ~cycle_hold_n_i;
      advance    = run & buf_in_ready;
      selected   = ~select_a_n_i & select_b_i & ~select_c_n_i;
      step_count = `SB_CNT_W'(count + `SB_CNT_STEP);
      if (advance_or_load_i) begin
         if (!burst_live) begin
            new_kind = sram_burst_pkg::kind_idle_cycle;
         end else if (burst_wr) begin
            new_kind = sram_burst_pkg::kind_burst_write;
         end else begin
            new_kind = sram_burst_pkg::kind_burst_read;
         end
      end else if (!selected) begin
         new_kind = sram_burst_pkg::kind_deselect;
      end else if (read_not_write_i) begin
         new_kind = sram_burst_pkg::kind_load_read;
      end else begin
         new_kind = sram_burst_pkg::kind_load_write;
      end

      next_kind       = kind;
      next_burst_live = burst_live;
      next_burst_wr   = burst_wr;
      next_base_addr  = base_addr;
      next_count      = count;
      next_stage_beat = stage_beat;
      beat_rd         = 1'b0;
      beat_wr         = 1'b0;
      beat_addr       = base_addr;

      case (new_kind)
         sram_burst_pkg::kind_load_read,
         sram_burst_pkg::kind_load_write: begin
            beat_addr = address_i;
            beat_rd   = (new_kind == sram_burst_pkg::kind_load_read);
            beat_wr   = ~beat_rd;
         end
         sram_burst_pkg::kind_burst_read,
         sram_burst_pkg::kind_burst_write: begin
            beat_addr = {base_addr[`SB_ADDR_W-1:`SB_CNT_W],
                         burst_low(base_addr[`SB_CNT_W-1:0], step_count, burst_order_sel_i)};
            beat_rd   = ~burst_wr;
            beat_wr   = burst_wr;
         end
         sram_burst_pkg::kind_deselect,
         sram_burst_pkg::kind_idle_cycle: begin
            beat_rd = 1'b0;
            beat_wr = 1'b0;
         end
         default: begin
            beat_rd = 1'b0;
            beat_wr = 1'b0;
         end
      endcase

      // A held edge leaves every register as it was.
      // A refused edge does the same, so the command must be offered again.
      if (advance) begin
         next_kind       = new_kind;
         next_stage_beat = {beat_rd, beat_wr, beat_addr};
         case (new_kind)
            sram_burst_pkg::kind_load_read,
            sram_burst_pkg::kind_load_write: begin
               next_base_addr  = address_i;
               next_count      = `SB_CNT_RST;
               next_burst_live = 1'b1;
               next_burst_wr   = ~read_not_write_i;
            end
            sram_burst_pkg::kind_burst_read,
            sram_burst_pkg::kind_burst_write: begin
               next_count = step_count;
            end
            sram_burst_pkg::kind_deselect: begin
               next_burst_live = 1'b0;
            end
            default: begin
               next_count = count;
            end
         endcase
      end
   end

   // The reset only serves to make the first edges after it decode as idle
   // beats; the pins themselves need no reset to be obeyed.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         kind       <= sram_burst_pkg::kind_idle_cycle;
         burst_live <= 1'b0;
         burst_wr   <= 1'b0;
         base_addr  <= '0;
         count      <= `SB_CNT_RST;
         stage_beat <= '0;
      end else begin
         kind       <= next_kind;
         burst_live <= next_burst_live;
         burst_wr   <= next_burst_wr;
         base_addr  <= next_base_addr;
         count      <= next_count;
         stage_beat <= next_stage_beat;
      end
   end

   // ============================================================
   // Beat buffer between the command stage and the data stage.
   // Every taken edge pushes one beat, idle and deselect beats included, so
   // the distance between command and data never depends on the command mix.
   // The second entry absorbs a beat while bus_ready_i is low; once both
   // entries are full the command edge is refused and stall_o rises after it.

   logic                  head_valid;
   logic [`SB_BEAT_W-1:0] head_beat;
   logic                  pop;
   logic                  head_rd;
   logic                  head_wr;
   logic [`SB_ADDR_W-1:0] head_addr;

   beat_buffer #(
      .WIDTH (`SB_BEAT_W),
      .DEPTH (`SB_BUF_DEPTH)
   ) u_beat_buffer (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (advance),
      .in_data_i   (stage_beat),
      .in_ready_o  (buf_in_ready),
      .out_valid_o (head_valid),
      .out_data_o  (head_beat),
      .out_ready_i (pop)
   );

   // ============================================================
   // Data stage: the array is read and written as a beat leaves the buffer.
   // Lane selects and write data are taken at the edge on which the beat
   // leaves the buffer, two taken edges after its command. A write merges
   // the enabled lanes into the stored word; a read returns only the lanes
   // that exist in the present configuration, so missing lanes read as zero.

   // The array has no reset; a word that was never written reads back as
   // unknown bits.
   logic [`SB_DATA_W-1:0] mem [`SB_MEM_DEPTH];
   logic [`SB_DATA_W-1:0] wmask;
   logic [`SB_DATA_W-1:0] wword;
   logic                  wen;
   logic [`SB_DATA_W-1:0] next_data_out;
   logic                  next_data_oe;
   logic                  next_stall;

   always_comb begin
      pop       = run & bus_ready_i & head_valid;
      head_rd   = head_beat[`SB_BEAT_W-1];
      head_wr   = head_beat[`SB_BEAT_W-2];
      head_addr = head_beat[`SB_ADDR_W-1:0];
      wmask     = lane_mask(byte_lane_write_n_i, narrow_config_i);
      wword     = (mem[head_addr] & ~wmask) | (data_in_i & wmask);
      wen       = pop & head_wr & (wmask != '0);
      next_data_out = data_out_o;
      next_data_oe  = data_oe_o;
      if (pop) begin
         next_data_oe  = head_rd;
         next_data_out = head_rd ? (mem[head_addr] & lane_mask('0, narrow_config_i)) : '0;
      end
      next_stall = run & ~buf_in_ready;
   end

   always_ff @(posedge clk_i) begin
      if (wen) begin
         mem[head_addr] <= wword;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_out_o    <= '0;
         data_oe_o     <= 1'b0;
         cycle_kind_o  <= sram_burst_pkg::kind_idle_cycle;
         burst_count_o <= `SB_CNT_RST;
         stall_o       <= 1'b0;
      end else begin
         data_out_o    <= next_data_out;
         data_oe_o     <= next_data_oe;
         cycle_kind_o  <= next_kind;
         burst_count_o <= next_count;
         stall_o       <= next_stall;
      end
   end

endmodule

`default_nettype wire

// *** src/sram_burst_params.svh ***
`ifndef SRAM_BURST_PARAMS_SVH
`define SRAM_BURST_PARAMS_SVH

// ============================================================
// Geometry of the array and the data bus.
`define SB_ADDR_W       18
`define SB_MEM_DEPTH    (1 << `SB_ADDR_W)
`define SB_DATA_W       36
`define SB_LANES        4
`define SB_LANE_W       8
`define SB_PAR_LSB      32
`define SB_NARROW_LANES 2

// ============================================================
// Burst counter and pipeline.
`define SB_CNT_W        2
`define SB_CNT_RST      2'h0
`define SB_CNT_STEP     2'h1
`define SB_BEAT_W       (2 + `SB_ADDR_W)
`define SB_BUF_DEPTH    2

`endif

// *** src/sram_burst_pkg.sv ***
package sram_burst_pkg;

   // ============================================================
   // Kind of cycle decoded from the pins on an accepted edge.
   typedef enum logic [2:0] {
      kind_idle_cycle,
      kind_load_read,
      kind_load_write,
      kind_burst_read,
      kind_burst_write,
      kind_deselect
   } cycle_kind_t;

endpackage

// *** tb/controller_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module controller_model (
   input  wire logic        clk_i,
   input  wire logic        cycle_hold_n_i,
   input  wire logic        write_beat_i,
   input  wire logic [35:0] wdata_i,
   input  wire logic [3:0]  lanes_n_i,
   output logic      [35:0] data_o,
   output logic      [3:0]  lanes_n_o
);
   logic [40:0] stage = '0;

   initial data_o = '0;
   initial lanes_n_o = 4'hf;

   // Write data trails its command by two taken edges; between writes the lines toggle so stale data cannot pass.
   always @(posedge clk_i) begin
      if (!cycle_hold_n_i) begin
         stage     <= {write_beat_i, lanes_n_i, wdata_i};
         data_o    <= stage[40] ? stage[35:0] : ~data_o;
         lanes_n_o <= stage[40] ? stage[39:36] : 4'hf;
      end
   end
endmodule

`default_nettype wire

// *** tb/pipelined_sram_burst_control_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_params.svh"

module sram_control_checker (
   input wire logic                        clk_i,
   input wire logic                        reset_i,
   input wire logic                        cycle_hold_n_i,
   input wire logic                        read_not_write_i,
   input wire logic                        select_a_n_i,
   input wire logic                        select_b_i,
   input wire logic                        select_c_n_i,
   input wire logic                        advance_or_load_i,
   input wire logic                        bus_ready_i,
   input wire logic [`SB_DATA_W-1:0]       data_out_o,
   input wire logic                        data_oe_o,
   input wire sram_burst_pkg::cycle_kind_t cycle_kind_o,
   input wire logic [`SB_CNT_W-1:0]        burst_count_o,
   input wire logic                        stall_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   logic ready_q;
   logic go;
   logic sel_ok;
   logic live;
   logic live_rd;

   // The buffer holds at most one beat after an unheld edge with bus_ready_i high, and held
   // edges change nothing, so the next unheld edge with bus_ready_i high is taken.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ready_q <= 1'b1;
      end else if (!cycle_hold_n_i) begin
         ready_q <= bus_ready_i;
      end
   end
   assign go      = !cycle_hold_n_i && bus_ready_i && ready_q && !stall_o;
   assign sel_ok  = !select_a_n_i && select_b_i && !select_c_n_i;
   assign live_rd = cycle_kind_o inside {sram_burst_pkg::kind_load_read, sram_burst_pkg::kind_burst_read};
   assign live    = live_rd || cycle_kind_o inside {sram_burst_pkg::kind_load_write, sram_burst_pkg::kind_burst_write};

   chk_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !data_oe_o && !stall_o &&
      burst_count_o == 2'h0 && cycle_kind_o == sram_burst_pkg::kind_idle_cycle)
      else $error("outputs not quiet after reset");
   chk_read_data: assert property (go && sel_ok && !advance_or_load_i && read_not_write_i ##1 go ##1 go
      |=> data_oe_o) else $error("read data not driven two cycles after load");
   chk_deselect_release: assert property (go && !sel_ok && !advance_or_load_i ##1 go ##1 go
      |=> !data_oe_o) else $error("bus not released two cycles after deselect");
   chk_hold_freeze: assert property (cycle_hold_n_i |=> $stable(data_out_o) &&
      $stable(data_oe_o) && $stable(burst_count_o) && $stable(cycle_kind_o))
      else $error("state moved on a held edge");
   chk_load_count: assert property (go && sel_ok && !advance_or_load_i |=> burst_count_o == 2'h0 &&
      cycle_kind_o == ($past(read_not_write_i) ? sram_burst_pkg::kind_load_read : sram_burst_pkg::kind_load_write))
      else $error("load did not restart the burst");
   chk_burst_step: assert property (go && advance_or_load_i && live |=>
      burst_count_o == $past(burst_count_o) + 2'h1
      && cycle_kind_o == ($past(live_rd) ? sram_burst_pkg::kind_burst_read : sram_burst_pkg::kind_burst_write))
      else $error("burst advance wrong");
   chk_advance_idle: assert property (go && advance_or_load_i && !live |=>
      cycle_kind_o == sram_burst_pkg::kind_idle_cycle && $stable(burst_count_o))
      else $error("advance without burst did something");
   chk_deselect_kind: assert property (go && !sel_ok && !advance_or_load_i |=>
      cycle_kind_o == sram_burst_pkg::kind_deselect) else $error("deselect not decoded");
endmodule

`default_nettype wire

// *** tb/pipelined_sram_burst_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_params.svh"

module pipelined_sram_burst_control_test;
   typedef struct packed {
      logic hold; logic rnw; logic [2:0] sel; logic adv; logic order; logic [17:0] addr; logic [35:0] wd; logic [3:0] lanes;
   } row_t;
   typedef struct packed {logic act; logic rd; logic [17:0] addr; logic [35:0] wd; logic [3:0] lanes;} beat_t;

   logic clk = 1'b0, reset = 1'b1, hold_n = 1'b0, rnw = 1'b1, sel_a_n = 1'b1, sel_b = 1'b0, sel_c_n = 1'b1;
   logic adv = 1'b0, order = 1'b0, narrow = 1'b0, bus_ready = 1'b1, we = 1'b0, oe, stall;
   logic [17:0] addr = '0, base;
   logic [35:0] req_wd = '0, data_in, dout;
   logic [3:0]  req_lanes = 4'hf, lanes_n;
   logic [1:0]  cnt, bcnt;
   logic        live = 1'b0, is_rd = 1'b0;
   sram_burst_pkg::cycle_kind_t kind;
   logic [35:0] mem [logic [17:0]];
   beat_t       pend[$];
   int          n_fail = 0, num_checks = 0, cycles = 0;
   row_t idle = '{0, 1, 3'b110, 0, 0, 0, 0, 4'hf};
   row_t rows [18] = '{
      '{0, 0, 3'b010, 0, 0, 18'h0_0104, 36'h1_1111_1111, 4'h0}, '{0, 1, 3'b000, 1, 0, 0, 36'h2_2222_2222, 4'h0},
      '{0, 1, 3'b111, 1, 0, 0, 36'h3_3333_3333, 4'h0}, '{0, 0, 3'b010, 1, 0, 0, 36'h4_4444_4444, 4'h0},
      '{0, 0, 3'b010, 0, 0, 18'h0_0105, 36'ha_5a5a_5a5a, 4'ha}, '{0, 0, 3'b010, 0, 0, 18'h0_0106, 36'h5_ffff_ffff, 4'hf},
      '{0, 1, 3'b010, 0, 1, 18'h0_0106, 0, 4'h0}, '{0, 0, 3'b010, 1, 1, 0, 0, 4'h0}, '{0, 0, 3'b010, 1, 1, 0, 0, 4'h0},
      '{1, 0, 3'b010, 1, 1, 0, 0, 4'h0}, '{0, 0, 3'b010, 1, 1, 0, 0, 4'h0},
      '{0, 1, 3'b110, 0, 0, 0, 0, 4'h0}, '{0, 1, 3'b010, 1, 0, 0, 0, 4'h0},
      '{0, 1, 3'b000, 0, 0, 0, 0, 4'h0}, '{0, 1, 3'b010, 0, 0, 18'h0_0107, 0, 4'h0},
      '{0, 1, 3'b010, 1, 0, 0, 0, 4'h0}, '{0, 1, 3'b011, 0, 0, 0, 0, 4'h0},
      '{0, 1, 3'b110, 0, 0, 0, 0, 4'hf}};

   pipelined_sram_burst_control pipelined_sram_burst_control_inst (
      .clk_i(clk), .reset_i(reset), .cycle_hold_n_i(hold_n), .read_not_write_i(rnw), .select_a_n_i(sel_a_n),
      .select_b_i(sel_b), .select_c_n_i(sel_c_n), .advance_or_load_i(adv), .byte_lane_write_n_i(lanes_n),
      .burst_order_sel_i(order), .narrow_config_i(narrow), .address_i(addr), .data_in_i(data_in),
      .bus_ready_i(bus_ready), .data_out_o(dout), .data_oe_o(oe), .cycle_kind_o(kind),
      .burst_count_o(cnt), .stall_o(stall));
   controller_model controller_model_inst (
      .clk_i(clk), .cycle_hold_n_i(hold_n), .write_beat_i(we), .wdata_i(req_wd), .lanes_n_i(req_lanes),
      .data_o(data_in), .lanes_n_o(lanes_n));

   initial forever #4 clk = ~clk;

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic retire(input beat_t b);
      logic [35:0] cur;
      cur = mem.exists(b.addr) ? mem[b.addr] : 'x;
      if (b.act && !b.rd) begin
         for (int i = 0; i < 4; i++) begin
            if (!b.lanes[i] && (!narrow || i < 2)) begin
               cur[8*i+:8] = b.wd[8*i+:8];
               cur[32+i] = b.wd[32+i];
            end
         end
         mem[b.addr] = cur;
      end
      check({35'h0, oe}, {35'h0, b.act && b.rd});
      if (b.act && b.rd) begin
         check(dout, narrow ? cur & 36'h3_0000_ffff : cur);
      end
   endtask

   task automatic step(input row_t r);
      beat_t b;
      logic [38:0] keep;
      if (r.hold) begin
         hold_n = 1'b1;
         keep = {oe, cnt, dout};
         @(negedge clk);
         check(keep[35:0], dout);
         check({33'h0, keep[38:36]}, {33'h0, oe, cnt});
         hold_n = 1'b0;
      end
      if (pend.size() == 3) retire(pend.pop_front());
      {rnw, sel_a_n, sel_b, sel_c_n, adv, order, addr, req_wd, req_lanes} = r[63:0];
      b = '0;
      if (!r.adv && r.sel == 3'b010) begin
         {live, is_rd, base, bcnt} = {1'b1, r.rnw, r.addr, 2'h0};
         b.act = 1'b1;
      end else if (!r.adv) begin
         live = 1'b0;
      end else if (live) begin
         bcnt++;
         b.act = 1'b1;
      end
      b.rd = is_rd;
      b.addr = {base[17:2], r.order ? base[1:0] ^ bcnt : base[1:0] + bcnt};
      b.wd = r.wd;
      b.lanes = r.lanes;
      we = b.act && !b.rd;
      pend.push_back(b);
      @(negedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      check({29'h0, oe, cnt, kind, stall}, 36'h0);
      foreach (rows[i]) step(rows[i]);
      repeat (2) step(idle);
      narrow = 1'b1;
      step('{0, 0, 3'b010, 0, 0, 18'h0_0200, 36'hf_abcd_1234, 4'h0});
      step('{0, 1, 3'b010, 0, 0, 18'h0_0200, 0, 4'h0});
      repeat (3) step(idle);
      narrow = 1'b0;
      bus_ready = 1'b0;
      {rnw, sel_a_n, sel_b, sel_c_n, adv} = 5'b1_0100;
      repeat (6) @(negedge clk);
      check({35'h0, stall}, 36'h1);
      reset = 1'b1;
      bus_ready = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      pend.delete();
      live = 1'b0;
      check({29'h0, oe, cnt, kind, stall}, 36'h0);
      step('{0, 1, 3'b010, 0, 0, 18'h0_0105, 0, 4'h0});
      repeat (3) step(idle);
      print_verdict();
   end
endmodule

bind pipelined_sram_burst_control sram_control_checker sram_control_checker_inst (
   .clk_i(clk_i), .reset_i(reset_i), .cycle_hold_n_i(cycle_hold_n_i), .read_not_write_i(read_not_write_i),
   .select_a_n_i(select_a_n_i), .select_b_i(select_b_i), .select_c_n_i(select_c_n_i),
   .advance_or_load_i(advance_or_load_i), .bus_ready_i(bus_ready_i), .data_out_o(data_out_o),
   .data_oe_o(data_oe_o), .cycle_kind_o(cycle_kind_o), .burst_count_o(burst_count_o), .stall_o(stall_o));

`default_nettype wire
